// ===== sit_target.sv
// Summary of operation
// - Static logic, no minimum SCL rate, even stopped.
// - Sample SDA on each SCL rising edge.
// - Read bits driven after SCL low, held.
// - SDA output lags SCL fall by 300-350ns (synchroniser plus 200ns count).
// - Lines only pulled low, pull-up releases.
// - Idle within 20 ms after power-up.
// - Transfers framed by host Start and Stop.
// - First byte: address 0x38 plus direction.
// - Acknowledge received byte after eighth falling edge.
`timescale 1ns/1ps
module sit_target
  import sit_pkg::*;
#(
  parameter int POWERUP_CYC = PWRUP_CYC
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       scl_line,
  output logic            scl_drive,
  output logic            scl_oe,
  input  wire logic       sda_line,
  output logic            sda_drive,
  output logic            sda_oe,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic            bus_busy,
  output logic            link_ready
);

  // Two-flop synchronisers; the *_m flops feed only the next stage.
  logic             scl_m;
  logic             scl_s;
  logic             scl_q;
  logic             sda_m;
  logic             sda_s;
  logic             sda_q;

  sit_state_type    state;
  sit_state_type    next_state;
  logic       [3:0] bit_cnt;
  logic       [3:0] next_bit_cnt;
  logic       [7:0] shreg;
  logic       [7:0] next_shreg;
  logic       [7:0] txbyte;
  logic       [7:0] next_txbyte;
  logic             rw;
  logic             next_rw;
  logic             host_nack;
  logic             next_host_nack;
  logic             pend_oe;
  logic             next_pend_oe;
  logic [DLY_W-1:0] dly_cnt;
  logic [DLY_W-1:0] next_dly_cnt;
  logic             next_sda_oe;
  logic             next_bus_busy;
  logic             next_link_ready;
  logic             next_tx_ready;
  logic [PWR_W-1:0] pwr_cnt;
  logic [PWR_W-1:0] next_pwr_cnt;

  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;
  logic             sched;
  logic             sched_oe;
  logic             push;
  logic             push_ready;

  // Edges are found by oversampling SCL, so no SCL rate is too slow.
  assign scl_rise  = scl_s && !scl_q;
  assign scl_fall  = !scl_s && scl_q;
  assign start_det = scl_s && scl_q && sda_q && !sda_s;
  assign stop_det  = scl_s && scl_q && !sda_q && sda_s;

  sit_buf #(
    .WIDTH(BYTE_BITS)
  ) u_rx_buf (
    .clock    (clock),
    .rst      (rst),
    .in_data  (shreg),
    .in_valid (push),
    .in_ready (push_ready),
    .out_data (rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_txbyte     = txbyte;
    next_rw         = rw;
    next_host_nack  = host_nack;
    next_pend_oe    = pend_oe;
    next_dly_cnt    = dly_cnt;
    next_sda_oe     = sda_oe;
    next_bus_busy   = bus_busy;
    next_link_ready = link_ready;
    next_tx_ready   = 1'h0;
    next_pwr_cnt    = pwr_cnt;
    sched           = 1'h0;
    sched_oe        = 1'h0;
    push            = 1'h0;

    // Bus activity before the power-up wait ends is ignored entirely.
    if (state == st_power) begin
      if (pwr_cnt == PWR_W'(POWERUP_CYC - 1)) begin
        next_state      = st_idle;
        next_link_ready = 1'h1;
      end else begin
        next_pwr_cnt = pwr_cnt + 1'h1;
      end
    end else if (start_det || stop_det) begin
      next_bit_cnt  = '0;
      next_shreg    = '0;
      next_sda_oe   = 1'h0;
      next_dly_cnt  = '0;
      next_bus_busy = start_det;
      next_state    = start_det ? st_addr : st_idle;
    end else begin
      if (dly_cnt != '0) begin
        next_dly_cnt = dly_cnt - 1'h1;
        if (dly_cnt == DLY_W'(1)) begin
          next_sda_oe = pend_oe;
        end
      end
      if (scl_rise) begin
        next_shreg   = {shreg[6:0], sda_s};
        next_bit_cnt = bit_cnt + 1'h1;
        if (state == st_rd_ack) begin
          next_host_nack = sda_s;
        end
      end
      if (scl_fall) begin
        case (state)
          st_addr: begin
            if (bit_cnt == ACK_BIT_POS) begin
              next_rw = shreg[0];
              if (shreg[7:1] == DEV_ADDR) begin
                next_state = st_addr_ack;
                sched      = 1'h1;
                sched_oe   = 1'h1;
              end else begin
                next_state = st_idle;
              end
            end
          end
          st_addr_ack, st_rd_ack: begin
            next_bit_cnt = '0;
            sched        = 1'h1;
            if (state == st_rd_ack && host_nack) begin
              next_state = st_idle;
            end else if (state == st_addr_ack && rw != DIR_READ) begin
              next_state = st_wr;
            end else begin
              // An empty transmit side returns all ones rather than stall SCL.
              next_txbyte   = tx_valid ? tx_data : 8'hff;
              next_tx_ready = tx_valid;
              sched_oe      = tx_valid ? !tx_data[7] : 1'h0;
              next_state    = st_rd;
            end
          end
          st_wr: begin
            if (bit_cnt == ACK_BIT_POS) begin
              // A full buffer is refused with a missing acknowledge.
              push = 1'h1;
              if (push_ready) begin
                next_state = st_wr_ack;
                sched      = 1'h1;
                sched_oe   = 1'h1;
              end else begin
                next_state = st_idle;
              end
            end
          end
          st_wr_ack: begin
            next_bit_cnt = '0;
            next_state   = st_wr;
            sched        = 1'h1;
          end
          st_rd: begin
            sched = 1'h1;
            if (bit_cnt == ACK_BIT_POS) begin
              next_state = st_rd_ack;
            end else begin
              sched_oe = !txbyte[3'(7 - bit_cnt)];
            end
          end
          default: begin
          end
        endcase
      end
      if (sched) begin
        next_pend_oe = sched_oe;
        next_dly_cnt = DLY_W'(TX_DLY_CYC);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      scl_m      <= LINE_IDLE;
      scl_s      <= LINE_IDLE;
      scl_q      <= LINE_IDLE;
      sda_m      <= LINE_IDLE;
      sda_s      <= LINE_IDLE;
      sda_q      <= LINE_IDLE;
      state      <= st_power;
      bit_cnt    <= '0;
      shreg      <= '0;
      txbyte     <= '0;
      rw         <= 1'h0;
      host_nack  <= 1'h0;
      pend_oe    <= 1'h0;
      dly_cnt    <= '0;
      sda_oe     <= 1'h0;
      sda_drive  <= 1'h0;
      scl_drive  <= 1'h0;
      scl_oe     <= 1'h0;
      bus_busy   <= 1'h0;
      link_ready <= 1'h0;
      tx_ready   <= 1'h0;
      pwr_cnt    <= '0;
    end else begin
      scl_m      <= scl_line;
      scl_s      <= scl_m;
      scl_q      <= scl_s;
      sda_m      <= sda_line;
      sda_s      <= sda_m;
      sda_q      <= sda_s;
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      txbyte     <= next_txbyte;
      rw         <= next_rw;
      host_nack  <= next_host_nack;
      pend_oe    <= next_pend_oe;
      dly_cnt    <= next_dly_cnt;
      sda_oe     <= next_sda_oe;
      // Open drain: the data driven is always low, only the enable moves.
      sda_drive  <= 1'h0;
      scl_drive  <= 1'h0;
      scl_oe     <= 1'h0;
      bus_busy   <= next_bus_busy;
      link_ready <= next_link_ready;
      tx_ready   <= next_tx_ready;
      pwr_cnt    <= next_pwr_cnt;
    end
  end

endmodule

// ===== sit_pkg.sv
package sit_pkg;

  // Fixed target address and read value of the direction bit in the first byte.
  localparam logic [6:0] DEV_ADDR      = 7'h38;
  localparam logic       DIR_READ      = 1'h1;
  localparam int         BYTE_BITS     = 8;
  localparam logic [3:0] ACK_BIT_POS   = 4'h8;

  // Timing in its own units, then in clock cycles of the 50 ns clock.
  localparam int         CLK_PERIOD_NS = 50;
  localparam int         TX_DELAY_NS   = 200;
  localparam int         POWERUP_MS    = 20;
  localparam int         TX_DLY_CYC    = TX_DELAY_NS / CLK_PERIOD_NS;
  localparam int         PWRUP_CYC     = POWERUP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int         DLY_W         = 3;
  localparam int         PWR_W         = 20;

  // Idle level of the released open-drain lines.
  localparam logic       LINE_IDLE     = 1'h1;

  typedef enum logic [2:0] {
    st_power,
    st_idle,
    st_addr,
    st_addr_ack,
    st_wr,
    st_wr_ack,
    st_rd,
    st_rd_ack
  } sit_state_type;

endpackage

// ===== sit_buf.sv
`timescale 1ns/1ps
module sit_buf
  import sit_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  // Two slots: the head drives the outputs directly from flops, the tail
  // catches the one word that may arrive while the head is stalled.
  logic [WIDTH-1:0] tail_data;
  logic             tail_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_tail_data;
  logic             next_tail_valid;

  assign in_ready = !tail_valid;

  always_comb begin
    next_out_data   = out_data;
    next_out_valid  = out_valid;
    next_tail_data  = tail_data;
    next_tail_valid = tail_valid;
    if (out_valid && out_ready) begin
      next_out_valid  = tail_valid;
      next_out_data   = tail_data;
      next_tail_valid = 1'h0;
    end
    if (in_valid && !tail_valid) begin
      if (!next_out_valid) begin
        next_out_valid = 1'h1;
        next_out_data  = in_data;
      end else begin
        next_tail_valid = 1'h1;
        next_tail_data  = in_data;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      out_data   <= '0;
      out_valid  <= 1'h0;
      tail_data  <= '0;
      tail_valid <= 1'h0;
    end else begin
      out_data   <= next_out_data;
      out_valid  <= next_out_valid;
      tail_data  <= next_tail_data;
      tail_valid <= next_tail_valid;
    end
  end

endmodule

// ===== sit_target_assertions.sv
`timescale 1ns/1ps
module sit_target_assertions
  import sit_pkg::*;
#(
  parameter int POWERUP_CYC = 20
) (
  input logic clock,
  input logic rst,
  input logic scl_line,
  input logic sda_line,
  input logic scl_drive,
  input logic scl_oe,
  input logic sda_drive,
  input logic sda_oe,
  input logic bus_busy,
  input logic link_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  int cnt;
  // Saturating, so a long run never wraps back under the power-up count.
  always_ff @(posedge clock) cnt <= rst ? 0 : (cnt < 999999999 ? cnt + 1 : cnt);
  sequence s_start;
    scl_line && !$past(sda_line, 3) && $past(sda_line, 5);
  endsequence
  sequence s_stop;
    scl_line && $past(sda_line, 3) && !$past(sda_line, 5);
  endsequence
  property p_od; !scl_oe && !scl_drive && !sda_drive; endproperty
  property p_low; $rose(sda_oe) |-> !scl_line; endproperty
  property p_lag; $rose(sda_oe) |-> !$past(scl_line, 6) && $past(scl_line, 8); endproperty
  property p_early; cnt < POWERUP_CYC - 1 |-> !link_ready; endproperty
  property p_late; cnt > POWERUP_CYC + 2 |-> link_ready; endproperty
  property p_busy; bus_busy |-> link_ready; endproperty
  property p_open; $rose(bus_busy) |-> s_start; endproperty
  property p_close; $fell(bus_busy) |-> s_stop; endproperty
  a_od: assert property (p_od) else $error("line driven");
  a_low: assert property (p_low) else $error("sda moved with scl high");
  a_lag: assert property (p_lag) else $error("sda lag wrong");
  a_early: assert property (p_early) else $error("ready too soon");
  a_late: assert property (p_late) else $error("ready too late");
  a_busy: assert property (p_busy) else $error("busy before ready");
  a_open: assert property (p_open) else $error("busy without start");
  a_close: assert property (p_close) else $error("idle without stop");
endmodule

bind sit_target sit_target_assertions #(.POWERUP_CYC(POWERUP_CYC)) u_chk (
  .clock(clock), .rst(rst), .scl_line(scl_line), .sda_line(sda_line),
  .scl_drive(scl_drive), .scl_oe(scl_oe), .sda_drive(sda_drive), .sda_oe(sda_oe),
  .bus_busy(bus_busy), .link_ready(link_ready));

// ===== sit_host.sv
`timescale 1ns/1ps
module sit_host
  import sit_pkg::*;
(
  input wire logic clock,
  input wire logic sda,
  output logic     scl_oe,
  output logic     sda_oe
);
  initial {scl_oe, sda_oe} = 2'h0;
  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask
  // SCL low lasts 12 clocks so the target's late SDA change lands before the rise.
  task automatic bitx(input logic b, output logic r);
    w(2);
    sda_oe = !b;
    w(10);
    scl_oe = 1'h0;
    w(7);
    r = sda;
    w(1);
    scl_oe = 1'h1;
  endtask
  task automatic start();
    if (scl_oe) begin
      w(2);
      sda_oe = 1'h0;
      w(10);
      scl_oe = 1'h0;
    end
    w(8);
    sda_oe = 1'h1;
    w(8);
    scl_oe = 1'h1;
  endtask
  task automatic stop();
    w(2);
    sda_oe = 1'h1;
    w(10);
    scl_oe = 1'h0;
    w(8);
    sda_oe = 1'h0;
    w(8);
  endtask
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) bitx(d[i], q[i]);
  endtask
endmodule

// ===== tb_sit_target.sv
`timescale 1ns/1ps
module tb_sit_target
  import sit_pkg::*;
;
  localparam int         PWR = 20;
  localparam logic [7:0] AW  = {DEV_ADDR, 1'h0};
  logic       clock, rst, rx_ready, tx_valid, rx_valid, tx_ready, bus_busy, link_ready;
  logic       scl_oe, scl_drive, sda_oe, sda_drive, h_scl, h_sda;
  logic [7:0] tx_data, rx_data;
  logic [8:0] q;
  int         err_total, num_checks, cyc, ntx;
  // Any enable pulls a line low; otherwise the pull-up wins.
  wire        scl = !(h_scl | scl_oe);
  wire        sda = !(h_sda | sda_oe);
  sit_target #(.POWERUP_CYC(PWR)) dut (
    .clock(clock), .rst(rst), .scl_line(scl), .scl_drive(scl_drive), .scl_oe(scl_oe),
    .sda_line(sda), .sda_drive(sda_drive), .sda_oe(sda_oe), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .bus_busy(bus_busy),
    .link_ready(link_ready));
  sit_host host (.clock(clock), .sda(sda), .scl_oe(h_scl), .sda_oe(h_sda));
  initial begin
    clock = 1'h0;
    forever #25 clock = !clock;
  end
  always @(negedge clock) begin
    if (tx_ready) begin
      ntx++;
      tx_valid <= 1'h0;
    end
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic getrx(input logic [7:0] exp);
    chk({rx_valid, rx_data}, {1'h1, exp});
    rx_ready = 1'h1;
    @(negedge clock);
    rx_ready = 1'h0;
  endtask
  task automatic t_power();
    chk(link_ready, 1'h0);
    host.w(PWR + 4);
    chk({bus_busy, link_ready}, 2'h1);
    $display("power-up test done");
  endtask
  task automatic t_write();
    host.start();
    chk(bus_busy, 1'h1);
    host.xfer({AW, 1'h1}, q);
    chk(q[0], 1'h0);
    host.xfer({8'ha5, 1'h1}, q);
    chk(q[0], 1'h0);
    host.xfer({8'h3c, 1'h1}, q);
    chk(q[0], 1'h0);
    // Receiver stalls, so the two-entry buffer is full and must refuse.
    host.xfer(9'h1ff, q);
    chk(q[0], 1'h1);
    host.stop();
    chk(bus_busy, 1'h0);
    getrx(8'ha5);
    getrx(8'h3c);
    chk(rx_valid, 1'h0);
    $display("write test done");
  endtask
  task automatic t_read();
    tx_data = 8'h96;
    tx_valid = 1'h1;
    ntx = 0;
    host.start();
    host.xfer({DEV_ADDR, DIR_READ, 1'h1}, q);
    chk(q[0], 1'h0);
    host.xfer(9'h1fe, q);
    chk(q, {8'h96, 1'h0});
    host.xfer(9'h1ff, q);
    chk(q, 9'h1ff);
    host.stop();
    chk(ntx[8:0], 9'h1);
    $display("read test done");
  endtask
  task automatic t_abort();
    host.start();
    host.xfer({DEV_ADDR ^ 7'h01, 1'h0, 1'h1}, q);
    chk(q[0], 1'h1);
    host.xfer(9'h001, q);
    host.start();
    host.xfer({AW, 1'h1}, q);
    for (int i = 0; i < 4; i++) host.bitx(1'h0, q[0]);
    host.start();
    host.xfer({AW, 1'h1}, q);
    chk(q[0], 1'h0);
    host.xfer({8'h5a, 1'h1}, q);
    host.stop();
    getrx(8'h5a);
    chk(rx_valid, 1'h0);
    $display("abort test done");
  endtask
  initial begin
    rst = 1'h1;
    rx_ready = 1'h0;
    tx_valid = 1'h0;
    tx_data = 8'h00;
    repeat (16) @(negedge clock);
    rst = 1'h0;
    t_power();
    t_write();
    t_read();
    t_abort();
    finish_test();
  end
endmodule
